// file: hw/bdp_pkg.sv
// Purpose : Shared constants and types for one port of the banked memory
// Assumes : One clock per port, 250 MHz, active-low async reset
// Notes   : Bank number sits above the in-bank word address
package bdp_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int BDP_BANK_W = 6;      // Six bank-select bits
    localparam int BDP_WORD_W = 12;     // Word address inside a bank
    localparam int BDP_LANE_W = 9;      // One byte lane
    localparam int BDP_DATA_W = 18;     // Two lanes
    localparam int BDP_ADDR_W = 18;     // Bank plus word
    localparam int BDP_LOW_LSB  = 0;    // Lower lane position
    localparam int BDP_HIGH_LSB = 9;    // Upper lane position

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [17:0] BDP_ADDR_RST = 18'h00000;
    localparam logic [17:0] BDP_DATA_RST = 18'h00000;

    // Access kind, one-hot
    typedef enum logic [2:0] {
        BDP_IDLE  = 3'h1,
        BDP_READ  = 3'h2,
        BDP_WRITE = 3'h4
    } bdp_kind_t;

    // One port command as sampled at the clock edge
    typedef struct packed {
        logic        sel;       // Chip selected
        logic        wr;        // Write level on direction input
        logic [1:0]  lane_n;    // {upper, lower} enables, active low
        logic [17:0] addr;      // Address used for the access
        logic [17:0] wdata;     // Write data
    } bdp_cmd_t;

endpackage : bdp_pkg

// file: hw/bdp_counter.sv
// Purpose : Port address counter with load, advance, hold and reload
// Assumes : Inputs synchronous to SYS_CLK
// Notes   : Wraps across banks and from the top bank to bank zero
`timescale 1ns/100ps
module bdp_counter
    import bdp_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  address_strobe_n,
    input  wire logic                  count_advance_n,
    input  wire logic                  reload_n,
    input  wire logic [BDP_ADDR_W-1:0] ext_addr,
    output logic      [BDP_ADDR_W-1:0] addr_used
);

    logic [BDP_ADDR_W-1:0] cnt_q, cnt_d;
    logic [BDP_ADDR_W-1:0] last_q, last_d;

    // ------------------------------------------------------------------
    // Next address; enables and chip selects take no part
    // ------------------------------------------------------------------
    always_comb begin
        last_d = last_q;
        if (!reload_n) begin
            cnt_d = last_q;
        end else if (!address_strobe_n) begin
            cnt_d  = ext_addr;
            last_d = ext_addr;
        end else if (!count_advance_n) begin
            cnt_d = cnt_q + 18'h00001;
        end else begin
            cnt_d = cnt_q;
        end
    end

    // Address registers; reload value is cleared only for determinism
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q  <= BDP_ADDR_RST;
            last_q <= BDP_ADDR_RST;
        end else begin
            cnt_q  <= cnt_d;
            last_q <= last_d;
        end
    end

    assign addr_used = cnt_d;

    // Wrap from top of bank 63 goes to zero
    AST_CNT_WRAP: assert property (@(posedge clk) disable iff (!arst_n)
        (reload_n && address_strobe_n && !count_advance_n
         && cnt_q == 18'h3FFFF) |=> cnt_q == 18'h00000)
        else $error("counter did not wrap to bank zero");

    AST_CNT_RELOAD: assert property (@(posedge clk) disable iff (!arst_n)
        (!reload_n) |=> cnt_q == $past(last_q))
        else $error("reload did not restore last strobed address");

    AST_CNT_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
        (reload_n && address_strobe_n && count_advance_n)
        |=> $stable(cnt_q))
        else $error("counter moved while held");

    AST_CNT_BANK: assert property (@(posedge clk) disable iff (!arst_n)
        (reload_n && address_strobe_n && !count_advance_n
         && cnt_q[11:0] == 12'hFFF && cnt_q[17:12] != 6'h3F)
        |=> cnt_q[17:12] == $past(cnt_q[17:12]) + 6'h01
            && cnt_q[11:0] == 12'h000)
        else $error("counter did not cross into next bank");

endmodule : bdp_counter

// file: hw/bdp_port.sv
// Purpose : One port of a two-port banked memory: access, lanes, counter
// Assumes : Inputs synchronous to SYS_CLK; output enable is asynchronous
// Notes   : Memory array lives here; far port is seen only by its bank, activity and write level
`timescale 1ns/100ps

// Notes on behaviour
// - Write edge stores only byte lanes whose enables are low.
// - Read with output enable low drives only enabled lanes.
// - Output enable high floats all data pins with no clock.
// - Any lane combination is legal; both disabled means no access.
// - Deselected port floats data and drops into standby.
// - Strobe low loads external bank and word address each edge.
// - Count enable low advances counter when strobe and reload high.
// - All three high reuses counter address unchanged.
// - Reload low restores last strobed address, above everything else.
// - Addressing ignores chip and lane enables.
// - Reload address undefined at power-up; every strobe with reload high updates it.
// - Counter covers bank and word; FFFh advances to next bank.
// - Top word of bank 63 advances to bank zero word zero.
// - Pipelined mode gives read data one cycle after flow-through.
// - Port may use any bank the far port is not using.
// - Same bank on both ports makes both accesses invalid; a read clashing with a far writer returns stored data.
module bdp_port
    import bdp_pkg::*;
#(
    parameter int DEPTH = 1 << BDP_ADDR_W
)
(
    input  wire logic                  SYS_CLK,
    input  wire logic                  ARST_N,
    input  wire logic                  CHIP_SELECT_LOW_N,
    input  wire logic                  CHIP_SELECT_HIGH,
    input  wire logic                  WRITE_N_READ,
    input  wire logic                  OUTPUT_ENABLE_N,
    input  wire logic                  UPPER_LANE_ENABLE_N,
    input  wire logic                  LOWER_LANE_ENABLE_N,
    input  wire logic [BDP_BANK_W-1:0] MEMORY_BLOCK_PICK,
    input  wire logic [BDP_WORD_W-1:0] WORD_ADDR,
    input  wire logic                  ADDRESS_STROBE_N,
    input  wire logic                  COUNT_ADVANCE_N,
    input  wire logic                  RELOAD_N,
    input  wire logic                  PIPELINE_SELECT,
    input  wire logic [BDP_BANK_W-1:0] FAR_BANK,
    input  wire logic                  FAR_ACTIVE,
    input  wire logic                  FAR_WRITE,
    input  wire logic [BDP_DATA_W-1:0] DATA_IN,
    output logic      [BDP_DATA_W-1:0] DATA_OUT,
    output logic      [BDP_DATA_W-1:0] DATA_OE_N,
    output logic                       STANDBY,
    output logic                       BANK_CLASH,
    output logic      [BDP_BANK_W-1:0] BANK_USED
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Expand two lane enables to a per-bit enable mask
    function automatic logic [BDP_DATA_W-1:0] lane_mask(
        input logic [1:0] lane_n
    );
        lane_mask = {{BDP_LANE_W{~lane_n[1]}}, {BDP_LANE_W{~lane_n[0]}}};
    endfunction : lane_mask

    // ------------------------------------------------------------------
    // Address counter
    // ------------------------------------------------------------------
    logic [BDP_ADDR_W-1:0] addr_used;

    bdp_counter u_counter (
        .clk              (SYS_CLK),
        .arst_n           (ARST_N),
        .address_strobe_n (ADDRESS_STROBE_N),
        .count_advance_n  (COUNT_ADVANCE_N),
        .reload_n         (RELOAD_N),
        .ext_addr         ({MEMORY_BLOCK_PICK, WORD_ADDR}),
        .addr_used        (addr_used)
    );

    // ------------------------------------------------------------------
    // Command decode at the clock edge
    // ------------------------------------------------------------------
    bdp_cmd_t  cmd;
    bdp_kind_t kind;
    logic      clash;

    // Sample controls; the chip is selected only with both enables true
    always_comb begin
        cmd.sel    = !CHIP_SELECT_LOW_N && CHIP_SELECT_HIGH;
        cmd.wr     = !WRITE_N_READ;
        cmd.lane_n = {UPPER_LANE_ENABLE_N, LOWER_LANE_ENABLE_N};
        cmd.addr   = addr_used;
        cmd.wdata  = DATA_IN;
        clash = cmd.sel && FAR_ACTIVE
                && (FAR_BANK == addr_used[17:12]);
        if (!cmd.sel || cmd.lane_n == 2'h3) begin
            kind = BDP_IDLE;
        end else if (cmd.wr) begin
            kind = BDP_WRITE;
        end else begin
            kind = BDP_READ;
        end
    end

    // ------------------------------------------------------------------
    // Memory array, lane-masked write
    // ------------------------------------------------------------------
    logic [BDP_DATA_W-1:0] mem [DEPTH];
    logic [BDP_DATA_W-1:0] rd_word;

    // Write only enabled lanes; a clash with a far writer corrupts nothing
    // here beyond dropping this access
    always_ff @(posedge SYS_CLK) begin
        if (kind == BDP_WRITE && !clash) begin
            if (!cmd.lane_n[0]) begin
                mem[cmd.addr][8:0] <= cmd.wdata[8:0];
            end
            if (!cmd.lane_n[1]) begin
                mem[cmd.addr][17:9] <= cmd.wdata[17:9];
            end
        end
    end

    assign rd_word = mem[cmd.addr];

    // ------------------------------------------------------------------
    // Read pipeline: stage one is flow-through, stage two pipelined
    // ------------------------------------------------------------------
    logic [BDP_DATA_W-1:0] s1_data_q, s1_data_d, s2_data_q, s2_data_d;
    logic [BDP_DATA_W-1:0] s1_en_q, s1_en_d, s2_en_q, s2_en_d;
    logic                  standby_q, standby_d, clash_q, clash_d;
    logic [BDP_BANK_W-1:0] bank_q, bank_d;

    // Next read data and lane enables; invalid data on a read clash with a reading far port
    always_comb begin
        s1_en_d = (kind == BDP_READ) ? lane_mask(cmd.lane_n)
                                     : {BDP_DATA_W{1'b0}};
        s1_data_d = rd_word;
        if (kind == BDP_READ && clash && !FAR_WRITE) begin
            s1_data_d = {BDP_DATA_W{1'b1}};
        end
        s2_data_d = s1_data_q;
        s2_en_d   = s1_en_q;
        standby_d = !cmd.sel;
        clash_d   = clash;
        bank_d    = cmd.sel ? addr_used[17:12] : bank_q;
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s1_data_q <= BDP_DATA_RST;
            s2_data_q <= BDP_DATA_RST;
            s1_en_q   <= {BDP_DATA_W{1'b0}};
            s2_en_q   <= {BDP_DATA_W{1'b0}};
            standby_q <= 1'b1;
            clash_q   <= 1'b0;
            bank_q    <= {BDP_BANK_W{1'b0}};
        end else begin
            s1_data_q <= s1_data_d;
            s2_data_q <= s2_data_d;
            s1_en_q   <= s1_en_d;
            s2_en_q   <= s2_en_d;
            standby_q <= standby_d;
            clash_q   <= clash_d;
            bank_q    <= bank_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs; output enable gates pins without a clock
    // ------------------------------------------------------------------
    logic [BDP_DATA_W-1:0] drive_en;

    assign drive_en  = PIPELINE_SELECT ? s2_en_q : s1_en_q;
    assign DATA_OUT  = PIPELINE_SELECT ? s2_data_q : s1_data_q;
    assign DATA_OE_N = OUTPUT_ENABLE_N ? {BDP_DATA_W{1'b1}}
                                       : ~drive_en;
    assign STANDBY    = standby_q;
    assign BANK_CLASH = clash_q;
    assign BANK_USED  = bank_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_read_lower;
        kind == BDP_READ && !cmd.lane_n[0] && cmd.lane_n[1];
    endsequence

    AST_OE_FLOAT: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        OUTPUT_ENABLE_N |-> &DATA_OE_N)
        else $error("data driven while output enable high");

    AST_FT_LOWER: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (s_read_lower and !PIPELINE_SELECT) ##1 !OUTPUT_ENABLE_N
        |-> DATA_OE_N == 18'h3FE00)
        else $error("flow-through read lane enables wrong");

    AST_PL_DELAY: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (kind == BDP_READ && PIPELINE_SELECT && cmd.lane_n == 2'h0)
        ##1 PIPELINE_SELECT ##1 (PIPELINE_SELECT && !OUTPUT_ENABLE_N)
        |-> DATA_OE_N == 18'h00000)
        else $error("pipelined read not driven one cycle later");

    AST_DESEL: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (CHIP_SELECT_LOW_N || !CHIP_SELECT_HIGH)
        |=> STANDBY && (PIPELINE_SELECT || &DATA_OE_N))
        else $error("deselected port not floated or not in standby");

    AST_NO_LANE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (cmd.lane_n == 2'h3 && !PIPELINE_SELECT)
        |=> &DATA_OE_N)
        else $error("pins driven with both lanes disabled");

    AST_CLASH: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (cmd.sel && FAR_ACTIVE && FAR_BANK == addr_used[17:12])
        |=> BANK_CLASH)
        else $error("bank clash not flagged");

    // ------------------------------------------------------------------
    // Checks on lanes, latency, standby and bank use
    // ------------------------------------------------------------------
    sequence s_read_upper;
        kind == BDP_READ && cmd.lane_n[0] && !cmd.lane_n[1];
    endsequence

    sequence s_read_clash;
        kind == BDP_READ && clash && !FAR_WRITE;
    endsequence

    sequence s_selected;
        !CHIP_SELECT_LOW_N && CHIP_SELECT_HIGH;
    endsequence

    // Upper-only flow-through read drives bits 17 to 9
    AST_FT_UPPER: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (s_read_upper and !PIPELINE_SELECT) ##1 !OUTPUT_ENABLE_N
        |-> DATA_OE_N == 18'h001FF)
        else $error("flow-through upper read lane enables wrong");

    // A write never turns the pins around, flow-through
    AST_WR_FLOAT: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (kind == BDP_WRITE && !PIPELINE_SELECT)
        |=> &DATA_OE_N)
        else $error("data pins driven after a write");

    // A write never turns the pins around, pipelined
    AST_WR_PL_FLOAT: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (kind == BDP_WRITE && PIPELINE_SELECT) ##1 PIPELINE_SELECT
        |=> &DATA_OE_N)
        else $error("data pins driven two edges after a write");

    // Pipelined read is not yet out one edge after its access
    AST_PL_LATE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (kind != BDP_READ && PIPELINE_SELECT)
        ##1 (kind == BDP_READ && PIPELINE_SELECT) ##1 PIPELINE_SELECT
        |-> &DATA_OE_N)
        else $error("pipelined read appeared one cycle early");

    // Clash read with a reading far port gives all ones, flow-through
    AST_CLASH_DATA: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (s_read_clash and !PIPELINE_SELECT)
        |=> DATA_OUT == 18'h3FFFF)
        else $error("clash read data not forced high");

    // Same clash read data one edge later when pipelined
    AST_CLASH_PL: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (s_read_clash and PIPELINE_SELECT) ##1 PIPELINE_SELECT
        |=> DATA_OUT == 18'h3FFFF)
        else $error("pipelined clash read data not forced high");

    // Deselect floats the pins in pipelined mode too
    AST_DESEL_PL: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ((CHIP_SELECT_LOW_N || !CHIP_SELECT_HIGH) && PIPELINE_SELECT)
        ##1 PIPELINE_SELECT |=> &DATA_OE_N)
        else $error("pipelined deselect did not float the pins");

    // Both lanes off floats the pins in pipelined mode too
    AST_NO_LANE_PL: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (cmd.lane_n == 2'h3 && PIPELINE_SELECT) ##1 PIPELINE_SELECT
        |=> &DATA_OE_N)
        else $error("pipelined pins driven with both lanes disabled");

    // A selected edge wakes the port
    AST_AWAKE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        s_selected |=> !STANDBY)
        else $error("selected port left in standby");

    // A selected edge records the bank it used
    AST_BANK_USED: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        s_selected |=> BANK_USED == $past(addr_used[17:12]))
        else $error("bank in use not recorded");

    // Distinct banks never raise the clash flag
    AST_NO_CLASH: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        !clash |=> !BANK_CLASH)
        else $error("clash flagged for distinct banks");

    // Strobe without reload uses the external address at once
    AST_STROBE_ADDR: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (!ADDRESS_STROBE_N && RELOAD_N)
        |-> addr_used == {MEMORY_BLOCK_PICK, WORD_ADDR})
        else $error("strobed address not used for the access");

endmodule : bdp_port

// file: dv/bdp_far_host.sv
// Purpose : Model of the opposite port's host for bank traffic
// Assumes : Bench names the bank this port is about to use
// Notes   : Steers clear of that bank unless a clash is ordered
`timescale 1ns/100ps
module bdp_far_host
    import bdp_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic [BDP_BANK_W-1:0] avoid_bank,
    input  wire logic                  clash_req,
    output logic      [BDP_BANK_W-1:0] far_bank,
    output logic                       far_active,
    output logic                       far_write
);
    // ------------------------------------------------------------------
    // Far port traffic, launched just after the falling edge
    // ------------------------------------------------------------------
    // A clash is always a read on the far side
    always @(negedge clk) begin
        #0.5;
        far_active <= clash_req | 1'($urandom % 2);
        far_write  <= ~clash_req & 1'($urandom % 2);
        far_bank   <= clash_req ? avoid_bank
                    : avoid_bank ^ 6'(1 + $urandom % 63);
    end
endmodule : bdp_far_host

// file: dv/tb_bdp_port.sv
// Purpose : Self-checking bench for one port of the banked memory
// Assumes : Far port host comes from bdp_far_host
// Notes   : Flow-through then pipelined, directed then random
`timescale 1ns/100ps
module tb_bdp_port
    import bdp_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [17:0] oe;
        logic [17:0] d;
        logic [17:0] m;
    } bdp_stage_t;
    logic        clk = 1'b0;
    logic        arst_n, csl_n, csh, wr_n, oe_n, ub_n, lb_n, as_n;
    logic        cnt_n, rl_n, pipe, clash_req, standby, clash;
    logic        far_act, far_wr;
    logic [5:0]  bank, far_bank, avoid_bank, bank_used;
    logic [11:0] word;
    logic [17:0] din, dout, doe_n, cnt, last;
    logic [17:0] mem [int];
    logic [17:0] vm  [int];
    bdp_stage_t  st  [2];
    logic [7:0]  exp_ctl;
    int          bad_count;
    int          comparisons;

    always #2 clk = ~clk;

    bdp_port bdp_port_i (
        .SYS_CLK(clk), .ARST_N(arst_n), .CHIP_SELECT_LOW_N(csl_n),
        .CHIP_SELECT_HIGH(csh), .WRITE_N_READ(wr_n), .OUTPUT_ENABLE_N(oe_n),
        .UPPER_LANE_ENABLE_N(ub_n), .LOWER_LANE_ENABLE_N(lb_n),
        .MEMORY_BLOCK_PICK(bank), .WORD_ADDR(word), .ADDRESS_STROBE_N(as_n),
        .COUNT_ADVANCE_N(cnt_n), .RELOAD_N(rl_n), .PIPELINE_SELECT(pipe),
        .FAR_BANK(far_bank), .FAR_ACTIVE(far_act), .FAR_WRITE(far_wr),
        .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(doe_n),
        .STANDBY(standby), .BANK_CLASH(clash), .BANK_USED(bank_used)
    );

    bdp_far_host bdp_far_host_i (
        .clk(clk), .avoid_bank(avoid_bank), .clash_req(clash_req),
        .far_bank(far_bank), .far_active(far_act), .far_write(far_wr)
    );

    // ------------------------------------------------------------------
    // Expectation, comparison and verdict
    // ------------------------------------------------------------------
    function automatic logic [17:0] next_addr(input logic a, c, r,
                                              input logic [17:0] ext);
        if (!r) return last;
        if (!a) return ext;
        if (!c) return cnt + 18'h00001;
        return cnt;
    endfunction : next_addr

    task automatic cmp_data(input logic [17:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t data got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_data

    task automatic cmp_ctl(input logic [7:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t ctl got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_ctl

    task automatic close_out;
        $display("Counts: comparisons=%0d mismatches=%0d",
                 comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    task automatic do_reset(input logic p);
        {arst_n, pipe, csl_n, csh, wr_n, oe_n, ub_n, lb_n} = {1'b0, p, 6'h2B};
        {bank, word, as_n, cnt_n, rl_n, clash_req} = {18'h0, 4'hE};
        din = 18'h00000;
        avoid_bank = 6'h00;
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        {cnt, last} = 36'h0;
        st[0] = {18'h3FFFF, 36'h0};
        st[1] = st[0];
        exp_ctl = 8'h80;
    endtask : do_reset

    // One access: check last results, drive, then advance the model
    task automatic cycle(input logic s, w, input logic [1:0] ln,
                         input logic [5:0] b, input logic [11:0] wd,
                         input logic a, c, r, q);
        logic [17:0] ad, lm;
        bdp_stage_t  cur;
        @(negedge clk);
        cur = pipe ? st[1] : st[0];
        lm = ~cur.oe & cur.m;
        cmp_data(dout & lm, cur.d & lm);
        cmp_ctl({standby, clash, bank_used}, exp_ctl);
        csl_n = s ? 1'b0 : 1'($urandom % 2);
        csh = s | (csl_n & 1'($urandom % 2));
        {wr_n, ub_n, lb_n, bank, word} = {~w, ln, b, wd};
        {as_n, cnt_n, rl_n, clash_req} = {a, c, r, q};
        din = 18'($urandom);
        oe_n = ($urandom % 8 == 0);
        ad = next_addr(a, c, r, {b, wd});
        avoid_bank = ad[17:12];
        #1;
        cmp_data(doe_n, oe_n ? 18'h3FFFF : cur.oe);
        if (r && !a)
            last = {b, wd};
        cnt = ad;
        lm = {{9{~ln[1]}}, {9{~ln[0]}}};
        st[1] = st[0];
        st[0].oe = (s && !w) ? ~lm : 18'h3FFFF;
        st[0].d = mem.exists(ad) ? mem[ad] : 18'h0;
        st[0].m = vm.exists(ad) ? vm[ad] : 18'h0;
        if (s && q) begin
            st[0].d = 18'h3FFFF;
            st[0].m = 18'h3FFFF;
        end else if (s && w) begin
            if (!mem.exists(ad)) begin
                mem[ad] = 18'h0;
                vm[ad] = 18'h0;
            end
            mem[ad] = mem[ad] & ~lm | din & lm;
            vm[ad] = vm[ad] | lm;
        end
        exp_ctl = s ? {1'b0, q, ad[17:12]} : {2'b10, exp_ctl[5:0]};
    endtask : cycle

    // Bank and counter corners, reload, lanes and clash
    task automatic directed;
        cycle(1, 1, 2'h0, 6'h00, 12'hFFF, 0, 1, 1, 0);
        cycle(1, 0, 2'h0, 6'h00, 12'h000, 1, 0, 1, 0);
        cycle(1, 0, 2'h0, 6'h3F, 12'hFFF, 0, 1, 1, 0);
        cycle(1, 0, 2'h0, 6'h05, 12'h000, 1, 0, 1, 0);
        cycle(0, 0, 2'h0, 6'h05, 12'h000, 1, 0, 1, 0);
        cycle(1, 0, 2'h0, 6'h05, 12'h000, 1, 1, 1, 0);
        cycle(1, 0, 2'h0, 6'h05, 12'h000, 1, 0, 0, 0);
        for (int k = 0; k < 4; k++) begin
            cycle(1, 1, 2'(k), 6'h02, 12'(k), 0, 1, 1, 0);
            cycle(1, 0, 2'(k + 1), 6'h02, 12'(k), 0, 1, 1, 0);
        end
        cycle(1, 1, 2'h0, 6'h07, 12'h000, 0, 1, 1, 0);
        cycle(1, 1, 2'h0, 6'h07, 12'h000, 0, 1, 1, 1);
        cycle(1, 0, 2'h0, 6'h07, 12'h000, 0, 1, 1, 1);
        cycle(1, 0, 2'h0, 6'h07, 12'h000, 0, 1, 1, 0);
    endtask : directed

    task automatic run_random(input int n);
        logic r;
        repeat (n) begin
            r = ($urandom % 8 != 0);
            cycle($urandom % 8 != 0, 1'($urandom), 2'($urandom),
                  6'($urandom % 2 * 62 + $urandom % 2),
                  12'(($urandom % 2) ? 4094 + $urandom % 2 : $urandom % 4),
                  ~r | 1'($urandom), 1'($urandom), r,
                  $urandom % 16 == 0);
        end
    endtask : run_random

    // Main sequence, both output modes
    initial begin
        void'($urandom(94484));
        bad_count = 0;
        comparisons = 0;
        do_reset(1'b0);
        directed();
        run_random(600);
        @(negedge clk);                 // Let the last access land
        do_reset(1'b1);
        directed();
        run_random(600);
        close_out();
    end

    // Watchdog: about three times the expected run of about 1280 cycles
    initial begin
        #(4200 * 4);
        bad_count++;
        close_out();
    end
endmodule : tb_bdp_port
